// ===== logic/fic_params.svh
// Register indices, field positions, reset values and timing counts for the fault interrupt block
`ifndef FIC_PARAMS_SVH
`define FIC_PARAMS_SVH

`define FIC_IDX_PIN_MON 8'h27
`define FIC_IDX_CONFIG 8'h28
`define FIC_IDX_MASK0 8'h29
`define FIC_IDX_MASK1 8'h2a
`define FIC_IDX_LATCH0 8'h2c
`define FIC_IDX_LATCH1 8'h2d

`define FIC_RST_CONFIG 8'h00
`define FIC_RST_MASK0 8'hff
`define FIC_RST_MASK1 8'h03

`define FIC_POS_POL 7
`define FIC_POS_EVT_LO 5
`define FIC_POS_SHUT_LO 3
`define FIC_POS_READBACK 2
`define FIC_POS_RECOVERY 1
`define FIC_POS_CLEAR 0

`define FIC_CLK_KHZ 250000
`define FIC_PULSE_MS 2
`define FIC_PERIOD_MS 4
`define FIC_PULSE_CYCLES (`FIC_PULSE_MS * `FIC_CLK_KHZ)
`define FIC_PERIOD_CYCLES (`FIC_PERIOD_MS * `FIC_CLK_KHZ)

`endif

// ===== logic/fic_pkg.sv
// Types shared by the fault interrupt block
package fic_pkg;

    typedef enum logic [1:0]
    {
        FIC_EVT_LEVEL = 2'h0,
        FIC_EVT_RSVD = 2'h1,
        FIC_EVT_PERIODIC = 2'h2,
        FIC_EVT_ONESHOT = 2'h3
    } fic_event_mode_t;

    typedef enum logic [1:0]
    {
        FIC_SHUT_NONE = 2'h0,
        FIC_SHUT_UNMASKED = 2'h1,
        FIC_SHUT_ALL = 2'h2,
        FIC_SHUT_RSVD = 2'h3
    } fic_shutdown_mode_t;

endpackage

// ===== logic/fic_pulse_timer.sv
// Periodic and one-shot pulse timer for the attention output
`timescale 1ns/1ps
module fic_pulse_timer
#(
    parameter int PULSE_CYCLES = 500000,
    parameter int PERIOD_CYCLES = 1000000
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic periodic_run,
    input wire logic oneshot_trigger,
    output logic periodic_active,
    output logic oneshot_active
);
    localparam int CW = $clog2(PERIOD_CYCLES + 1);

    logic [CW-1:0] period_cnt;
    logic [CW-1:0] shot_cnt;
    logic [CW-1:0] next_period_cnt;
    logic [CW-1:0] next_shot_cnt;

    always_comb
    begin
        next_period_cnt = '0;
        if (periodic_run && period_cnt != CW'(PERIOD_CYCLES - 1))
        begin
            next_period_cnt = period_cnt + CW'(1);
        end
        next_shot_cnt = shot_cnt;
        if (oneshot_trigger)
        begin
            next_shot_cnt = CW'(PULSE_CYCLES);
        end
        else if (shot_cnt != '0)
        begin
            next_shot_cnt = shot_cnt - CW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            period_cnt <= '0;
            shot_cnt <= '0;
        end
        else
        begin
            period_cnt <= next_period_cnt;
            shot_cnt <= next_shot_cnt;
        end
    end

    assign periodic_active = periodic_run && (period_cnt < CW'(PULSE_CYCLES));
    assign oneshot_active = (shot_cnt != '0);

endmodule

// ===== logic/fic_top.sv
// Interrupt configuration, fault shutdown and pin level monitor with APB access
// Functional notes
// - Monitor bits 7-5 show synced multi-purpose pin levels when set as inputs.
// - Monitor bits 4-3 show synced input-only pin levels when set as inputs.
// - Monitor bits 2-0 always read zero; writes are ignored.
// - Config bit 7 picks attention level: zero active low, one active high.
// - Event field zero: attention held while any unmasked latched bit is set.
// - Event field two: 2 ms asserted per 4 ms while unmasked latch set.
// - Event field three: one 2 ms pulse per new unmasked event.
// - Shutdown field zero: faults never power down channels or bias.
// - Shutdown field one: unmasked channel faults power down that channel.
// - Shutdown field two: any channel fault powers down that channel.
// - Readback bit: one shows only unmasked latched bits, masked read zero.
// - Recovery bit zero: channels power back up when the fault goes.
// - Clear bit zero: read clears latched bit only when its live status is zero.
// - Clear bit one: read always clears; re-set only on live rising edge.
// - Config register is read/write and resets to zero.
// - A mask bit of one excludes its source; zero includes it.
// - Latched bits set on events, clear per clear mode, reset to zero.
`timescale 1ns/1ps
`include "fic_params.svh"
module fic_top
#(
    parameter int PULSE_CYCLES = `FIC_PULSE_CYCLES,
    parameter int PERIOD_CYCLES = `FIC_PERIOD_CYCLES,
    parameter int CHANNELS = 2
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] multi_pin_level_in,
    input wire logic [1:0] input_pin_level_in,
    input wire logic [4:0] pin_is_general_input,
    input wire logic [3:0] system_event_live,
    input wire logic [CHANNELS-1:0] channel_fault_live,
    input wire logic bias_shutdown_setting,
    input wire logic [CHANNELS-1:0] channel_powerup_register,
    output logic attention_pin,
    output logic [CHANNELS-1:0] channel_powerdown,
    output logic mic_supply_bias_off
);
    import fic_pkg::*;

    localparam int NSRC = 4 + CHANNELS;

    function automatic logic idx_hit(input logic [9:0] addr, input logic [7:0] idx);
        idx_hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    // Pin synchronisers
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end
        else
        begin
            pin_meta <= {multi_pin_level_in, input_pin_level_in};
            pin_sync <= pin_meta;
        end
    end

    // Configuration and mask registers
    logic [7:0] interrupt_config;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] next_interrupt_config;
    logic [7:0] next_mask0;
    logic [7:0] next_mask1;
    logic wr_en;
    logic rd_done;

    assign wr_en = psel && penable && pwrite;
    assign rd_done = psel && penable && !pwrite;

    always_comb
    begin
        next_interrupt_config = interrupt_config;
        next_mask0 = mask0;
        next_mask1 = mask1;
        if (wr_en && idx_hit(paddr, `FIC_IDX_CONFIG))
        begin
            next_interrupt_config = pwdata[7:0];
        end
        if (wr_en && idx_hit(paddr, `FIC_IDX_MASK0))
        begin
            next_mask0 = pwdata[7:0];
        end
        if (wr_en && idx_hit(paddr, `FIC_IDX_MASK1))
        begin
            next_mask1 = pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            interrupt_config <= `FIC_RST_CONFIG;
            mask0 <= `FIC_RST_MASK0;
            mask1 <= `FIC_RST_MASK1;
        end
        else
        begin
            interrupt_config <= next_interrupt_config;
            mask0 <= next_mask0;
            mask1 <= next_mask1;
        end
    end

    // Field decode
    logic attention_polarity;
    fic_event_mode_t event_mode;
    fic_shutdown_mode_t fault_shutdown_mode;
    logic latched_readback_mode;
    logic fault_recovery_mode;
    logic latched_clear_mode;
    logic [NSRC-1:0] src_mask;
    logic [NSRC-1:0] src_live;

    assign attention_polarity = interrupt_config[`FIC_POS_POL];
    assign event_mode = fic_event_mode_t'(interrupt_config[`FIC_POS_EVT_LO +: 2]);
    assign fault_shutdown_mode = fic_shutdown_mode_t'(interrupt_config[`FIC_POS_SHUT_LO +: 2]);
    assign latched_readback_mode = interrupt_config[`FIC_POS_READBACK];
    assign fault_recovery_mode = interrupt_config[`FIC_POS_RECOVERY];
    assign latched_clear_mode = interrupt_config[`FIC_POS_CLEAR];
    assign src_mask = {mask0[7:4], mask1[7:8-CHANNELS]};
    assign src_live = {system_event_live, channel_fault_live};

    // Latched status
    logic [NSRC-1:0] latched_status;
    logic [NSRC-1:0] live_prev;
    logic [NSRC-1:0] rd_snap;
    logic [NSRC-1:0] next_latched_status;
    logic [NSRC-1:0] set_evt;
    logic [NSRC-1:0] read_clr;
    logic [NSRC-1:0] rd_region;

    always_comb
    begin
        rd_region = '0;
        if (idx_hit(paddr, `FIC_IDX_LATCH0))
        begin
            rd_region[NSRC-1:CHANNELS] = 4'hf;
        end
        if (idx_hit(paddr, `FIC_IDX_LATCH1))
        begin
            rd_region[CHANNELS-1:0] = '1;
        end
        // Clear only what was latched when the read was captured, masked or not
        read_clr = rd_done ? (rd_snap & rd_region) : '0;
        if (latched_clear_mode)
        begin
            set_evt = src_live & ~live_prev;
        end
        else
        begin
            set_evt = src_live;
            read_clr = read_clr & ~src_live;
        end
        next_latched_status = (latched_status & ~read_clr) | set_evt;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            latched_status <= '0;
            live_prev <= '0;
        end
        else
        begin
            latched_status <= next_latched_status;
            live_prev <= src_live;
        end
    end

    // Attention output
    logic any_unmasked;
    logic new_unmasked;
    logic periodic_active;
    logic oneshot_active;
    logic attention_asserted;
    logic next_attention_pin;

    assign any_unmasked = |(latched_status & ~src_mask);
    assign new_unmasked = |(src_live & ~live_prev & ~src_mask);

    fic_pulse_timer #(
        .PULSE_CYCLES(PULSE_CYCLES),
        .PERIOD_CYCLES(PERIOD_CYCLES)
    ) u_pulse_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .periodic_run(event_mode == FIC_EVT_PERIODIC && any_unmasked),
        .oneshot_trigger(event_mode == FIC_EVT_ONESHOT && new_unmasked),
        .periodic_active(periodic_active),
        .oneshot_active(oneshot_active)
    );

    always_comb
    begin
        unique case (event_mode)
            FIC_EVT_PERIODIC: attention_asserted = periodic_active;
            FIC_EVT_ONESHOT: attention_asserted = oneshot_active;
            FIC_EVT_LEVEL: attention_asserted = any_unmasked;
            FIC_EVT_RSVD: attention_asserted = any_unmasked;
        endcase
        next_attention_pin = attention_polarity ? attention_asserted : !attention_asserted;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            attention_pin <= 1'b1;
        end
        else
        begin
            attention_pin <= next_attention_pin;
        end
    end

    // Fault shutdown
    logic [CHANNELS-1:0] chan_trip;
    logic bias_trip;
    logic [CHANNELS-1:0] next_channel_powerdown;
    logic next_mic_supply_bias_off;

    always_comb
    begin
        chan_trip = '0;
        bias_trip = 1'b0;
        unique case (fault_shutdown_mode)
            FIC_SHUT_UNMASKED:
            begin
                chan_trip = channel_fault_live & ~src_mask[CHANNELS-1:0];
                bias_trip = |system_event_live[1:0];
            end
            FIC_SHUT_ALL:
            begin
                chan_trip = channel_fault_live;
                bias_trip = |system_event_live[1:0];
            end
            FIC_SHUT_NONE: chan_trip = '0;
            FIC_SHUT_RSVD: chan_trip = '0;
        endcase
        bias_trip = bias_trip && bias_shutdown_setting;
        next_mic_supply_bias_off = bias_trip;
        chan_trip = chan_trip | {CHANNELS{bias_trip}};
        if (fault_recovery_mode)
        begin
            // Held until software powers the channel up with the fault gone
            next_channel_powerdown = chan_trip |
                (channel_powerdown & ~channel_powerup_register);
        end
        else
        begin
            next_channel_powerdown = chan_trip;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            channel_powerdown <= '0;
            mic_supply_bias_off <= 1'b0;
        end
        else
        begin
            channel_powerdown <= next_channel_powerdown;
            mic_supply_bias_off <= next_mic_supply_bias_off;
        end
    end

    // APB read path, captured in the setup cycle
    logic [7:0] pin_level_monitor;
    logic [NSRC-1:0] latched_view;
    logic [7:0] rd_byte;
    logic rd_mapped;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [NSRC-1:0] next_rd_snap;

    assign pin_level_monitor = {pin_sync & pin_is_general_input, 3'h0};
    assign latched_view = latched_readback_mode ?
        (latched_status & ~src_mask) : latched_status;

    always_comb
    begin
        rd_byte = 8'h00;
        rd_mapped = 1'b1;
        if (idx_hit(paddr, `FIC_IDX_PIN_MON))
        begin
            rd_byte = pin_level_monitor;
        end
        else if (idx_hit(paddr, `FIC_IDX_CONFIG))
        begin
            rd_byte = interrupt_config;
        end
        else if (idx_hit(paddr, `FIC_IDX_MASK0))
        begin
            rd_byte = mask0;
        end
        else if (idx_hit(paddr, `FIC_IDX_MASK1))
        begin
            rd_byte = mask1;
        end
        else if (idx_hit(paddr, `FIC_IDX_LATCH0))
        begin
            rd_byte = {latched_view[NSRC-1:CHANNELS], 4'h0};
        end
        else if (idx_hit(paddr, `FIC_IDX_LATCH1))
        begin
            rd_byte = {latched_view[CHANNELS-1:0], {(8-CHANNELS){1'b0}}};
        end
        else
        begin
            rd_mapped = 1'b0;
        end
        next_prdata = prdata;
        next_pslverr = pslverr;
        next_rd_snap = rd_snap;
        if (psel && !penable)
        begin
            next_prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            next_pslverr = !rd_mapped;
            next_rd_snap = latched_status;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            rd_snap <= '0;
        end
        else
        begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            rd_snap <= next_rd_snap;
        end
    end

    assign pready = 1'b1;

endmodule

// ===== test/fic_props.sv
// Concurrent checks on the fault interrupt block ports
`timescale 1ns/1ps
module fic_props
#(
    parameter int PULSE_CYCLES = 4
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [3:0] system_event_live,
    input wire logic [1:0] channel_fault_live,
    input wire logic bias_shutdown_setting,
    input wire logic attention_pin,
    input wire logic [1:0] channel_powerdown,
    input wire logic mic_supply_bias_off
);
    logic [7:0] cfg;
    logic [7:0] next_cfg;
    logic [7:0] mask0;
    logic [7:0] next_mask0;
    logic wr_go;
    logic mapped;
    assign wr_go = psel && penable && pwrite;
    assign mapped = paddr inside {10'h09c, 10'h0a0, 10'h0a4, 10'h0a8, 10'h0b0, 10'h0b4};
    // Shadow of config and mask0 seen on the bus
    always_comb
    begin
        next_cfg = cfg;
        next_mask0 = mask0;
        if (wr_go && paddr == 10'h0a0)
            next_cfg = pwdata[7:0];
        if (wr_go && paddr == 10'h0a4)
            next_mask0 = pwdata[7:0];
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg <= 8'h00;
            mask0 <= 8'hff;
        end
        else
        begin
            cfg <= next_cfg;
            mask0 <= next_mask0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    unmapped_err_a: assert property (
        psel && !penable && !mapped |=> pslverr)
        else $error("no error on unmapped access");
    mon_reserved_a: assert property (
        psel && penable && paddr == 10'h09c |-> prdata[2:0] == 3'h0)
        else $error("monitor low bits not zero");
    cfg_readback_a: assert property (
        psel && penable && !pwrite && paddr == 10'h0a0 |-> prdata == {24'h00_0000, cfg})
        else $error("config readback differs");
    masked_read_a: assert property (
        psel && penable && !pwrite && paddr == 10'h0b0 && cfg[2]
        |-> (prdata[7:4] & mask0[7:4]) == 4'h0) else $error("masked latch bit visible");
    shut_none_a: assert property (
        cfg[4:3] == 2'h0 && $past(cfg[4:3]) == 2'h0 && !cfg[1] && !$past(cfg[1])
        |-> channel_powerdown == 2'h0 && !mic_supply_bias_off) else $error("power down in mode 0");
    shut_all_a: assert property (
        cfg[4:3] == 2'h2 && channel_fault_live[0] |=> channel_powerdown[0])
        else $error("channel not powered down");
    auto_recover_a: assert property (
        cfg[4:3] == 2'h2 && !cfg[1] && !channel_fault_live[1]
        && !(bias_shutdown_setting && |system_event_live[1:0]) |=> !channel_powerdown[1])
        else $error("channel not recovered");
    oneshot_pulse_a: assert property (
        cfg[6:5] == 2'h3 && !mask0[4] && $rose(system_event_live[0])
        |-> ##2 (attention_pin == cfg[7]) [*4]) else $error("one shot pulse wrong");
    cover property (cfg[6:5] == 2'h2 && $rose(attention_pin));
    cover property (psel && penable && pslverr);
    cover property ($rose(channel_powerdown[1]));
endmodule

bind fic_top fic_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_props
(
    .core_clk(core_clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pslverr(pslverr),
    .system_event_live(system_event_live),
    .channel_fault_live(channel_fault_live),
    .bias_shutdown_setting(bias_shutdown_setting),
    .attention_pin(attention_pin),
    .channel_powerdown(channel_powerdown),
    .mic_supply_bias_off(mic_supply_bias_off)
);

// ===== test/fic_host_model.sv
// Host side model that counts cycles of asserted attention
`timescale 1ns/1ps
module fic_host_model
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic attention_pin,
    input wire logic active_high,
    output int asserted_cycles
);
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            asserted_cycles <= 0;
        else if (attention_pin === active_high)
            asserted_cycles <= asserted_cycles + 1;
    end
endmodule

// ===== test/tb.sv
// Self-checking bench for the fault interrupt block
`timescale 1ns/1ps
module tb;
    localparam logic [9:0] a_mon = 10'h09c;
    localparam logic [9:0] a_cfg = 10'h0a0;
    localparam logic [9:0] a_m0 = 10'h0a4;
    localparam logic [9:0] a_m1 = 10'h0a8;
    localparam logic [9:0] a_l0 = 10'h0b0;
    localparam logic [9:0] a_l1 = 10'h0b4;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] multi_pin_level_in = 3'h0;
    logic [1:0] input_pin_level_in = 2'h0;
    logic [4:0] pin_is_general_input = 5'h00;
    logic [3:0] system_event_live = 4'h0;
    logic [1:0] channel_fault_live = 2'h0;
    logic bias_shutdown_setting = 1'b0;
    logic [1:0] channel_powerup_register = 2'h0;
    logic attention_pin;
    logic [1:0] channel_powerdown;
    logic mic_supply_bias_off;
    logic pol = 1'b0;
    int host_cnt;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2 core_clk = ~core_clk;
    fic_top #(.PULSE_CYCLES(4), .PERIOD_CYCLES(8)) u_dut
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .multi_pin_level_in(multi_pin_level_in),
        .input_pin_level_in(input_pin_level_in),
        .pin_is_general_input(pin_is_general_input),
        .system_event_live(system_event_live),
        .channel_fault_live(channel_fault_live),
        .bias_shutdown_setting(bias_shutdown_setting),
        .channel_powerup_register(channel_powerup_register),
        .attention_pin(attention_pin),
        .channel_powerdown(channel_powerdown),
        .mic_supply_bias_off(mic_supply_bias_off)
    );
    fic_host_model u_host
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .attention_pin(attention_pin),
        .active_high(pol),
        .asserted_cycles(host_cnt)
    );
    task automatic give_verdict();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
            n_mismatch++;
        end
    endtask
    // Attention, bias off, channel power down, checked between edges
    task automatic outs(input logic [3:0] x);
        @(negedge core_clk);
        chk(32'({attention_pin, mic_supply_bias_off, channel_powerdown}), 32'(x));
        @(posedge core_clk);
    endtask
    task automatic apb(input logic wr_n, input logic [9:0] a, input logic [7:0] d,
        output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_n;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, {24'h00_0000, x});
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(a_cfg, 8'h00);
        rd(a_mon, 8'h00);
        rd(a_l0, 8'h00);
        outs(4'h8);
        wr(a_cfg, 8'h96);
        rd(a_cfg, 8'h96);
        wr(a_cfg, 8'h00);
        apb(1'b0, 10'h3fc, 8'h00, r, e);
        chk(32'(e), 32'h0000_0001);
        chk(r, 32'h0000_0000);
    endtask
    task automatic t_mon();
        multi_pin_level_in <= 3'h5;
        input_pin_level_in <= 2'h2;
        pin_is_general_input <= 5'h1f;
        w(3);
        rd(a_mon, 8'hb0);
        pin_is_general_input <= 5'h0f;
        w(2);
        rd(a_mon, 8'h30);
    endtask
    task automatic t_latch();
        wr(a_m0, 8'h00);
        system_event_live <= 4'h1;
        w(2);
        outs(4'h0);
        rd(a_l0, 8'h10);
        rd(a_l0, 8'h10);
        system_event_live <= 4'h0;
        rd(a_l0, 8'h10);
        rd(a_l0, 8'h00);
        w(2);
        outs(4'h8);
        wr(a_cfg, 8'h01);
        system_event_live <= 4'h1;
        w(2);
        rd(a_l0, 8'h10);
        rd(a_l0, 8'h00);
        system_event_live <= 4'h0;
        wr(a_m0, 8'h10);
        wr(a_cfg, 8'h04);
        system_event_live <= 4'h1;
        w(2);
        outs(4'h8);
        rd(a_l0, 8'h00);
        wr(a_cfg, 8'h00);
        rd(a_l0, 8'h10);
        system_event_live <= 4'h0;
        rd(a_l0, 8'h10);
        rd(a_l0, 8'h00);
    endtask
    task automatic t_pulse();
        int s;
        wr(a_m0, 8'h00);
        wr(a_cfg, 8'he0);
        pol <= 1'b1;
        w(2);
        @(negedge core_clk);
        s = host_cnt;
        w(1);
        system_event_live <= 4'h1;
        w(20);
        @(negedge core_clk);
        chk(host_cnt - s, 32'h0000_0004);
        w(1);
        system_event_live <= 4'h0;
        rd(a_l0, 8'h10);
        wr(a_cfg, 8'hc0);
        system_event_live <= 4'h1;
        w(4);
        @(negedge core_clk);
        s = host_cnt;
        w(32);
        @(negedge core_clk);
        chk(host_cnt - s, 32'h0000_0010);
        w(1);
        system_event_live <= 4'h0;
        rd(a_l0, 8'h10);
        w(2);
        outs(4'h0);
        wr(a_cfg, 8'h00);
        pol <= 1'b0;
    endtask
    task automatic t_shut();
        wr(a_m1, 8'hc0);
        wr(a_cfg, 8'h10);
        channel_fault_live <= 2'h1;
        w(2);
        outs(4'h9);
        channel_fault_live <= 2'h0;
        w(2);
        outs(4'h8);
        wr(a_cfg, 8'h12);
        channel_fault_live <= 2'h2;
        w(2);
        channel_fault_live <= 2'h0;
        w(4);
        outs(4'ha);
        channel_powerup_register <= 2'h2;
        w(1);
        channel_powerup_register <= 2'h0;
        w(2);
        outs(4'h8);
        wr(a_cfg, 8'h08);
        channel_fault_live <= 2'h2;
        w(2);
        outs(4'h8);
        wr(a_m1, 8'h40);
        w(2);
        outs(4'h2);
        wr(a_cfg, 8'h00);
        w(2);
        outs(4'h0);
        channel_fault_live <= 2'h0;
        rd(a_l1, 8'hc0);
        wr(a_m0, 8'hf0);
        wr(a_cfg, 8'h10);
        bias_shutdown_setting <= 1'b1;
        system_event_live <= 4'h2;
        w(2);
        outs(4'hf);
        system_event_live <= 4'h0;
        bias_shutdown_setting <= 1'b0;
        w(2);
        outs(4'h8);
        rd(a_l0, 8'h20);
    endtask
    initial
    begin
        w(8);
        reset_n <= 1'b1;
        t_regs();
        t_mon();
        t_latch();
        t_pulse();
        t_shut();
        give_verdict();
    end
endmodule
